// [sfc_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module sfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    rp_reg;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  assign push       = in_valid_i && in_ready_o;
  assign pop        = out_ready_i && out_valid_o;
  assign out_data_o = mem[rp_reg];

  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wp_reg] <= in_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Pointers and registered flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_reg      <= '0;
      rp_reg      <= '0;
      cnt_reg     <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg     <= cnt_next;
      in_ready_o  <= (cnt_next != (AW + 1)'(DEPTH));
      out_valid_o <= (cnt_next != '0);
    end
  end
endmodule : sfc_fifo
`default_nettype wire

// [sfc_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sfc_flash_model (
  // Flash pins
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] io_i,
  output logic            so_o,
  output logic            so_oe_o
);
  // --------------------------------
  // Single-lane device, no array behind it
  // --------------------------------
  logic [15:0] cnt_reg = 16'h0000;
  logic [15:0] sr_reg = 16'h0000;  // Nothing ever runs, so busy bit stays 0
  logic [7:0]  sh_reg, op_reg, prev_reg, dat_reg, out_reg, nb_reg;
  logic        oe_reg;
  wire logic   rd_v = (op_reg == 8'h05 || op_reg == 8'h35) ? cnt_reg >= 16'h0008 :
                      (op_reg == 8'h03) ? cnt_reg >= 16'h0020 :
                      (op_reg == 8'h0b) && cnt_reg >= 16'h0028;
  always @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      if (cnt_reg != 16'h0000 && cnt_reg[2:0] == 3'h0) begin
        case (op_reg)
          8'h06: sr_reg[1] <= 1'b1;
          8'h04, 8'h02: sr_reg[1] <= 1'b0;
          8'h99: if (prev_reg == 8'h66) sr_reg[1] <= 1'b0;
          default: ;
        endcase
      end
      if (cnt_reg >= 16'h0008) prev_reg <= op_reg;
      cnt_reg <= 16'h0000;
    end else if (io_i[3]) begin
      sh_reg  <= {sh_reg[6:0], io_i[0]};
      cnt_reg <= cnt_reg + 16'h0001;
      if (cnt_reg == 16'h0007) op_reg <= {sh_reg[6:0], io_i[0]};
      if (cnt_reg == 16'h001f) dat_reg <= {sh_reg[6:0], io_i[0]};
    end
  end
  always @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      oe_reg <= 1'b0;
      nb_reg <= 8'h00;
    end else if (cnt_reg[2:0] == 3'h0) begin
      oe_reg  <= rd_v;
      nb_reg  <= nb_reg + {7'h00, rd_v};
      out_reg <= (op_reg == 8'h05) ? sr_reg[7:0] :
                 (op_reg == 8'h35) ? sr_reg[15:8] : dat_reg + nb_reg;
    end else begin
      out_reg <= {out_reg[6:0], 1'b0};
    end
  end
  assign so_o    = out_reg[7];
  assign so_oe_o = oe_reg & io_i[3];
endmodule : sfc_flash_model
`default_nettype wire

// [sfc_host.sv]
`timescale 1ns/100ps
`default_nettype none
module sfc_host (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // Command port
  input  wire logic             cmd_valid_i,
  input  wire sfc_pkg::sfc_cmd_t cmd_i,
  output logic                  cmd_ready_o,
  input  wire logic             quad_ok_i,
  input  wire logic             pause_req_i,
  input  wire logic             abort_i,
  output logic                  done_o,
  output logic                  err_o,
  // Write data
  input  wire logic             wr_valid_i,
  input  wire logic [7:0]       wr_data_i,
  output logic                  wr_ready_o,
  // Read data
  output logic                  rd_valid_o,
  output logic [7:0]            rd_data_o,
  // Flash pins
  output logic                  sclk_o,
  output logic                  cs_n_o,
  output logic [3:0]            io_o,
  output logic [3:0]            io_oe_o,
  input  wire logic [3:0]       io_i
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LOAD  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_PAUSE = 3'h3,
    ST_END   = 3'h4
  } sfc_st_t;

  typedef enum logic [2:0] {
    PH_OP    = 3'h0,
    PH_ADDR  = 3'h1,
    PH_DUMMY = 3'h2,
    PH_WR    = 3'h3,
    PH_RD    = 3'h4,
    PH_DONE  = 3'h5
  } sfc_ph_t;

  sfc_st_t           st_reg;
  sfc_ph_t           ph_reg;
  sfc_pkg::sfc_dec_t dec_reg;
  sfc_pkg::sfc_dec_t dec_w;
  logic [23:0]       addr_reg;
  logic [15:0]       len_reg;
  logic [15:0]       left_reg;
  logic              endless_reg;
  logic [3:0]        clk_left_reg;
  logic [7:0]        div_reg;
  logic [7:0]        gap_reg;
  logic [7:0]        sh_reg;
  logic [7:0]        sh_next;
  logic              pause_n_reg;
  logic [7:0]        last_op_reg;
  logic [3:0]        io_meta_reg;
  logic [3:0]        io_sync_reg;
  logic              bad_w;
  logic              go_end;
  logic              fifo_pop;
  logic              fifo_vld;
  logic [7:0]        fifo_data;
  sfc_ph_t           ph_after;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] clocks_per_byte(input logic [1:0] ln);
    return 4'(4'h8 >> ln);
  endfunction : clocks_per_byte

  function automatic logic [1:0] ph_lanes(input sfc_ph_t ph, input sfc_pkg::sfc_dec_t d);
    logic [1:0] l;
    l = sfc_pkg::LN_1;
    if (ph == PH_ADDR || ph == PH_DUMMY) begin
      l = d.addr_ln;
    end else if (ph == PH_WR || ph == PH_RD) begin
      l = d.data_ln;
    end
    return l;
  endfunction : ph_lanes

  function automatic sfc_ph_t next_ph(input sfc_ph_t ph, input sfc_pkg::sfc_dec_t d);
    sfc_ph_t n;
    n = (d.dir == sfc_pkg::DIR_WR) ? PH_WR : (d.dir == sfc_pkg::DIR_RD) ? PH_RD : PH_DONE;
    if (ph == PH_OP && d.has_addr) begin
      n = PH_ADDR;
    end else if ((ph == PH_OP || ph == PH_ADDR) && d.has_dummy) begin
      n = PH_DUMMY;
    end else if (ph == PH_WR || ph == PH_RD || ph == PH_DONE) begin
      n = PH_DONE;
    end
    return n;
  endfunction : next_ph

  function automatic logic [15:0] ph_len(input sfc_ph_t ph, input sfc_pkg::sfc_dec_t d,
                                         input logic [15:0] len);
    logic [15:0] n;
    n = '0;
    if (ph == PH_ADDR) begin
      n = sfc_pkg::ADDR_BYTES;
    end else if (ph == PH_DUMMY) begin
      n = sfc_pkg::DUMMY_BYTES;
    end else if (ph == PH_WR || ph == PH_RD) begin
      n = d.fix_v ? d.fix_len : len;
    end
    return n;
  endfunction : ph_len

  // Lanes 2 and 3 stay write-protect high and pause unless the phase runs on four lanes
  function automatic logic [7:0] lane_drive(input logic [7:0] sh, input logic [1:0] ln,
                                            input logic rd, input logic pause_n);
    logic [3:0] v;
    logic [3:0] oe;
    v  = {pause_n, 1'b1, 1'b0, sh[7]};
    oe = sfc_pkg::IO_IDLE_OE;
    if (ln == sfc_pkg::LN_2) begin
      v  = {pause_n, 1'b1, sh[7:6]};
      oe = rd ? 4'hc : 4'hf;
    end else if (ln == sfc_pkg::LN_4) begin
      v  = sh[7:4];
      oe = rd ? 4'h0 : 4'hf;
    end else if (rd) begin
      v[0] = 1'b0;
    end
    return {oe, v};
  endfunction : lane_drive

  // MSB arrives first, so bits shift in from the bottom
  function automatic logic [7:0] lane_capture(input logic [7:0] sh, input logic [1:0] ln,
                                              input logic [3:0] s);
    logic [7:0] r;
    r = {sh[6:0], s[1]};
    if (ln == sfc_pkg::LN_2) begin
      r = {sh[5:0], s[1:0]};
    end else if (ln == sfc_pkg::LN_4) begin
      r = {sh[3:0], s[3:0]};
    end
    return r;
  endfunction : lane_capture

  // ----------------------------------------------------------------
  // Command check and write buffer
  // ----------------------------------------------------------------
  assign dec_w   = sfc_pkg::sfc_decode(cmd_i.opcode);
  assign bad_w   = (dec_w.quad && !quad_ok_i)
                || (dec_w.has_addr && cmd_i.addr > sfc_pkg::ADDR_MAX)
                || (cmd_i.opcode == sfc_pkg::OP_RESET_FIRE
                    && last_op_reg != sfc_pkg::OP_RESET_ARM);
  assign go_end  = (ph_reg == PH_DONE) || (left_reg == '0 && !endless_reg)
                || (abort_i && ph_reg == PH_RD);
  assign fifo_pop = (st_reg == ST_LOAD) && !go_end && (ph_reg == PH_WR) && fifo_vld;
  assign sh_next  = lane_capture(sh_reg, ph_lanes(ph_reg, dec_reg), io_sync_reg);
  assign ph_after = next_ph(ph_reg, dec_reg);

  sfc_fifo #(
    .WIDTH (sfc_pkg::FIFO_WIDTH),
    .DEPTH (sfc_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (wr_valid_i),
    .in_data_i   (wr_data_i),
    .in_ready_o  (wr_ready_o),
    .out_valid_o (fifo_vld),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_pop)
  );

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_meta_reg <= '0;
      io_sync_reg <= '0;
    end else begin
      io_meta_reg <= io_i;
      io_sync_reg <= io_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg       <= ST_IDLE;
      ph_reg       <= PH_DONE;
      dec_reg      <= '0;
      addr_reg     <= '0;
      len_reg      <= '0;
      left_reg     <= '0;
      endless_reg  <= 1'b0;
      clk_left_reg <= '0;
      div_reg      <= '0;
      gap_reg      <= '0;
      sh_reg       <= '0;
      pause_n_reg  <= 1'b1;
      last_op_reg  <= '0;
      sclk_o       <= 1'b0;
      cs_n_o       <= 1'b1;
      cmd_ready_o  <= 1'b1;
      done_o       <= 1'b0;
      err_o        <= 1'b0;
      rd_valid_o   <= 1'b0;
      rd_data_o    <= '0;
    end else begin
      done_o     <= 1'b0;
      err_o      <= 1'b0;
      rd_valid_o <= 1'b0;
      unique case (st_reg)
        ST_IDLE: begin
          if (cmd_valid_i) begin
            if (bad_w) begin
              err_o <= 1'b1;
            end else begin
              dec_reg     <= dec_w;
              addr_reg    <= cmd_i.addr;
              len_reg     <= cmd_i.len;
              ph_reg      <= PH_OP;
              left_reg    <= sfc_pkg::ONE_BYTE;
              endless_reg <= (dec_w.dir == sfc_pkg::DIR_RD) && !dec_w.fix_v
                             && (cmd_i.len == '0);
              last_op_reg <= cmd_i.opcode;
              cs_n_o      <= 1'b0;
              cmd_ready_o <= 1'b0;
              st_reg      <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          if (go_end) begin
            cs_n_o  <= 1'b1;
            gap_reg <= sfc_pkg::CS_GAP_CYC;
            st_reg  <= ST_END;
          end else if (ph_reg != PH_WR || fifo_vld) begin
            // Write data starving holds the clock low rather than breaking the frame
            unique case (ph_reg)
              PH_OP:   sh_reg <= last_op_reg;
              PH_ADDR: sh_reg <= addr_reg[23:16];
              PH_WR:   sh_reg <= fifo_data;
              default: sh_reg <= '0;
            endcase
            if (ph_reg == PH_ADDR) begin
              addr_reg <= {addr_reg[15:0], 8'h00};
            end
            clk_left_reg <= clocks_per_byte(ph_lanes(ph_reg, dec_reg));
            div_reg      <= '0;
            st_reg       <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!sclk_o && div_reg == '0 && pause_req_i && !dec_reg.quad) begin
            pause_n_reg <= 1'b0;
            st_reg      <= ST_PAUSE;
          end else if (div_reg == sfc_pkg::HALF_CYC - 8'h01) begin
            div_reg <= '0;
            sclk_o  <= ~sclk_o;
            if (sclk_o) begin
              sh_reg       <= sh_next;
              clk_left_reg <= clk_left_reg - 4'h1;
              if (clk_left_reg == 4'h1) begin
                st_reg <= ST_LOAD;
                if (ph_reg == PH_RD) begin
                  rd_valid_o <= 1'b1;
                  rd_data_o  <= sh_next;
                end
                if (!endless_reg) begin
                  if (left_reg == sfc_pkg::ONE_BYTE) begin
                    ph_reg   <= ph_after;
                    left_reg <= ph_len(ph_after, dec_reg, len_reg);
                  end else begin
                    left_reg <= left_reg - 16'h0001;
                  end
                end
              end
            end
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        ST_PAUSE: begin
          if (abort_i) begin
            cs_n_o      <= 1'b1;
            pause_n_reg <= 1'b1;
            gap_reg     <= sfc_pkg::CS_GAP_CYC;
            st_reg      <= ST_END;
          end else if (!pause_req_i) begin
            pause_n_reg <= 1'b1;
            div_reg     <= '0;
            st_reg      <= ST_SHIFT;
          end
        end
        ST_END: begin
          if (gap_reg == '0) begin
            cmd_ready_o <= 1'b1;
            done_o      <= 1'b1;
            ph_reg      <= PH_DONE;
            st_reg      <= ST_IDLE;
          end else begin
            gap_reg <= gap_reg - 8'h01;
          end
        end
        default: begin
          cs_n_o <= 1'b1;
          st_reg <= ST_END;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_o    <= sfc_pkg::IO_IDLE_VAL;
      io_oe_o <= sfc_pkg::IO_IDLE_OE;
    end else if (st_reg == ST_IDLE || st_reg == ST_END) begin
      io_o    <= sfc_pkg::IO_IDLE_VAL;
      io_oe_o <= sfc_pkg::IO_IDLE_OE;
    end else begin
      {io_oe_o, io_o} <= lane_drive(sh_reg, ph_lanes(ph_reg, dec_reg),
                                    ph_reg == PH_RD, pause_n_reg);
    end
  end

endmodule : sfc_host
`default_nettype wire

// [sfc_host_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module sfc_host_assertions (
  // Watched host ports
  input wire logic              sys_clk_i,
  input wire logic              rst_i,
  input wire logic              cmd_valid_i,
  input wire sfc_pkg::sfc_cmd_t cmd_i,
  input wire logic              cmd_ready_o,
  input wire logic              quad_ok_i,
  input wire logic              done_o,
  input wire logic              err_o,
  input wire logic              sclk_o,
  input wire logic              cs_n_o,
  input wire logic [3:0]        io_o,
  input wire logic [3:0]        io_oe_o
);
  // --------------------------------
  // Frame tracking
  // --------------------------------
  logic       take, quad_op, far, armed, paused, quad_reg;
  logic [7:0] last_reg, rise_reg;
  assign take   = cmd_valid_i & cmd_ready_o;
  assign quad_op = cmd_i.opcode inside {8'h6b, 8'heb, 8'h32};
  assign far    = cmd_i.addr > 24'h1fffff;
  assign armed  = last_reg == 8'h66;
  // Pause seen as lane 3 driven low; only meaningful outside quad frames
  assign paused = io_oe_o[3] & ~io_o[3];
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_reg <= 8'h00;
      quad_reg <= 1'b0;
      rise_reg <= 8'h00;
    end else begin
      if ($past(take) && !err_o) last_reg <= $past(cmd_i.opcode);
      if (take) quad_reg <= quad_op;
      rise_reg <= cs_n_o ? 8'h00 : rise_reg + {7'h00, $rose(sclk_o)};
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; take; endsequence
  sequence s_gap; cs_n_o [*5] ##[0:3] done_o; endsequence
  a_one_answer: assert property (s_take |=> err_o ^ !cs_n_o)
    else $error("accepted command gave no single answer");
  a_quad_refused: assert property (s_take ##0 quad_op && !quad_ok_i |=> err_o)
    else $error("quad command sent without quad enable");
  a_addr_refused: assert property (take && cmd_i.opcode == 8'h03 && far |=> err_o)
    else $error("address beyond array sent");
  a_fire_armed: assert property (take && cmd_i.opcode == 8'h99 |=> err_o == !$past(armed))
    else $error("reset fire not paired with arm");
  a_idle_low: assert property (cs_n_o |-> !sclk_o)
    else $error("serial clock not low while deselected");
  a_still_high: assert property (sclk_o |-> $stable(io_o & io_oe_o) && $stable(io_oe_o))
    else $error("lanes changed while clock high");
  a_byte_end: assert property ($rose(cs_n_o) && !$past(paused) |-> rise_reg[0] == 1'b0)
    else $error("frame ended off a lane boundary");
  a_pause_low: assert property (!quad_reg && !cs_n_o && paused |-> !sclk_o)
    else $error("clock high during pause");
  a_gap_done: assert property ($rose(cs_n_o) |-> s_gap)
    else $error("deselect gap or done wrong");
endmodule : sfc_host_assertions
bind sfc_host sfc_host_assertions u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .cmd_ready_o(cmd_ready_o), .quad_ok_i(quad_ok_i), .done_o(done_o), .err_o(err_o),
  .sclk_o(sclk_o), .cs_n_o(cs_n_o), .io_o(io_o), .io_oe_o(io_oe_o)
);
`default_nettype wire

// [sfc_pkg.sv]
package sfc_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LOWPOWER_READ       = 8'h03;
  localparam logic [7:0] OP_FAST_ARRAY_READ     = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUTPUT_READ    = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO_READ        = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUTPUT_READ    = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_READ        = 8'heb;
  localparam logic [7:0] OP_PAGE_ERASE          = 8'h81;
  localparam logic [7:0] OP_FOUR_KB_ERASE       = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE    = 8'h52;
  localparam logic [7:0] OP_FULL_BLOCK_ERASE    = 8'hd8;
  localparam logic [7:0] OP_CHIP_WIPE_A         = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_B         = 8'hc7;
  localparam logic [7:0] OP_PAGE_WRITE          = 8'h02;
  localparam logic [7:0] OP_DUAL_PAGE_WRITE     = 8'ha2;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE     = 8'h32;
  localparam logic [7:0] OP_PAUSE_CMD_A         = 8'h75;
  localparam logic [7:0] OP_PAUSE_CMD_B         = 8'hb0;
  localparam logic [7:0] OP_CONTINUE_CMD_A      = 8'h7a;
  localparam logic [7:0] OP_CONTINUE_CMD_B      = 8'h30;
  localparam logic [7:0] OP_LATCH_SET_CMD       = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR_CMD     = 8'h04;
  localparam logic [7:0] OP_VOLATILE_UNLOCK     = 8'h50;
  localparam logic [7:0] OP_SECREG_WIPE         = 8'h44;
  localparam logic [7:0] OP_SECREG_WRITE        = 8'h42;
  localparam logic [7:0] OP_SECREG_READ         = 8'h48;
  localparam logic [7:0] OP_STATUS_LOW_READ     = 8'h05;
  localparam logic [7:0] OP_STATUS_HIGH_READ    = 8'h35;
  localparam logic [7:0] OP_CONFIG_READ         = 8'h15;
  localparam logic [7:0] OP_STATUS_WRITE        = 8'h01;
  localparam logic [7:0] OP_CONFIG_WRITE        = 8'h31;
  localparam logic [7:0] OP_RESET_ARM           = 8'h66;
  localparam logic [7:0] OP_RESET_FIRE          = 8'h99;
  localparam logic [7:0] OP_IDENT_READ          = 8'h9f;

  // ----------------------------------------------------------------
  // Framing, array and timing
  // ----------------------------------------------------------------
  localparam logic [23:0] ADDR_MAX       = 24'h1fffff;
  localparam logic [15:0] ADDR_BYTES     = 16'h0003;
  localparam logic [15:0] DUMMY_BYTES    = 16'h0001;
  localparam logic [15:0] ONE_BYTE       = 16'h0001;
  localparam logic [15:0] TWO_BYTES      = 16'h0002;
  localparam logic [1:0]  LN_1           = 2'h0;
  localparam logic [1:0]  LN_2           = 2'h1;
  localparam logic [1:0]  LN_4           = 2'h2;
  localparam int          SYS_PERIOD_NS  = 10;
  localparam int          SCLK_PERIOD_NS = 160;
  localparam int          CS_GAP_NS      = 50;
  localparam logic [7:0]  HALF_CYC       = 8'(SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS));
  localparam logic [7:0]  CS_GAP_CYC     = 8'((CS_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam int          FIFO_WIDTH     = 8;
  localparam int          FIFO_DEPTH     = 8;
  localparam logic [3:0]  IO_IDLE_VAL    = 4'hc;
  localparam logic [3:0]  IO_IDLE_OE     = 4'hd;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DIR_NONE = 2'h0,
    DIR_WR   = 2'h1,
    DIR_RD   = 2'h2
  } sfc_dir_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [15:0] len;
  } sfc_cmd_t;

  typedef struct packed {
    logic        has_addr;
    logic        has_dummy;
    sfc_dir_t    dir;
    logic [1:0]  addr_ln;
    logic [1:0]  data_ln;
    logic        quad;
    logic        fix_v;
    logic [15:0] fix_len;
  } sfc_dec_t;

  function automatic sfc_dec_t sfc_decode(input logic [7:0] op);
    sfc_dec_t d;
    d = '0;
    d.dir = DIR_NONE;
    unique case (op)
      OP_LOWPOWER_READ, OP_FAST_ARRAY_READ, OP_SECREG_READ,
      OP_DUAL_OUTPUT_READ, OP_DUAL_IO_READ,
      OP_QUAD_OUTPUT_READ, OP_QUAD_IO_READ: begin
        d.has_addr  = 1'b1;
        d.has_dummy = (op != OP_LOWPOWER_READ);
        d.dir       = DIR_RD;
        d.data_ln   = (op == OP_DUAL_OUTPUT_READ || op == OP_DUAL_IO_READ) ? LN_2 :
                      (op == OP_QUAD_OUTPUT_READ || op == OP_QUAD_IO_READ) ? LN_4 : LN_1;
        d.addr_ln   = (op == OP_DUAL_IO_READ) ? LN_2 : (op == OP_QUAD_IO_READ) ? LN_4 : LN_1;
        d.quad      = (op == OP_QUAD_OUTPUT_READ || op == OP_QUAD_IO_READ);
      end
      OP_PAGE_ERASE, OP_FOUR_KB_ERASE, OP_HALF_BLOCK_ERASE,
      OP_FULL_BLOCK_ERASE, OP_SECREG_WIPE: begin
        d.has_addr = 1'b1;
      end
      OP_PAGE_WRITE, OP_DUAL_PAGE_WRITE, OP_QUAD_PAGE_WRITE, OP_SECREG_WRITE: begin
        d.has_addr = 1'b1;
        d.dir      = DIR_WR;
        d.data_ln  = (op == OP_DUAL_PAGE_WRITE) ? LN_2 :
                     (op == OP_QUAD_PAGE_WRITE) ? LN_4 : LN_1;
        d.quad     = (op == OP_QUAD_PAGE_WRITE);
      end
      OP_STATUS_LOW_READ, OP_STATUS_HIGH_READ, OP_CONFIG_READ: begin
        d.dir     = DIR_RD;
        d.fix_v   = 1'b1;
        d.fix_len = ONE_BYTE;
      end
      OP_STATUS_WRITE, OP_CONFIG_WRITE: begin
        d.dir     = DIR_WR;
        d.fix_v   = 1'b1;
        d.fix_len = (op == OP_STATUS_WRITE) ? TWO_BYTES : ONE_BYTE;
      end
      OP_IDENT_READ: begin
        d.dir = DIR_RD;
      end
      default: begin
        d.dir = DIR_NONE;
      end
    endcase
    return d;
  endfunction : sfc_decode

endpackage : sfc_pkg

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // --------------------------------
  // Bench
  // --------------------------------
  logic              sys_clk_i = 1'b0, rst_i = 1'b1, flip = 1'b0, cmd_valid_i = 1'b0;
  logic              quad_ok_i = 1'b0, pause_req_i = 1'b0, wr_valid_i = 1'b0;
  logic [7:0]        wr_data_i = 8'h00;
  sfc_pkg::sfc_cmd_t cmd_i = '0;
  logic              cmd_ready_o, done_o, err_o, wr_ready_o, rd_valid_o, sclk_o, cs_n_o;
  logic              so, so_oe;
  logic [7:0]        rd_data_o;
  logic [3:0]        io_o, io_oe_o, pin;
  int                n_errors = 0, samples_checked = 0;
  logic [7:0]        got[$];
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) flip <= ~flip;
  // Released lanes keep changing so a stale level can never pass
  assign pin[0] = io_oe_o[0] ? io_o[0] : flip;
  assign pin[1] = io_oe_o[1] ? io_o[1] : so_oe ? so : ~flip;
  assign pin[3:2] = {io_oe_o[3] ? io_o[3] : flip, io_oe_o[2] ? io_o[2] : ~flip};
  sfc_host DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .quad_ok_i(quad_ok_i),
    .pause_req_i(pause_req_i), .abort_i(1'b0), .done_o(done_o), .err_o(err_o),
    .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .sclk_o(sclk_o), .cs_n_o(cs_n_o),
    .io_o(io_o), .io_oe_o(io_oe_o), .io_i(pin));
  sfc_flash_model FLASH (.sclk_i(sclk_o), .cs_n_i(cs_n_o), .io_i(pin), .so_o(so),
    .so_oe_o(so_oe));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [15:0] n,
                     input logic e);
    int k;
    got.delete();
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i       <= {op, a, n};
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    #1;
    for (k = 0; k < 4000 && done_o !== 1'b1 && err_o !== 1'b1; k++) begin
      @(posedge sys_clk_i);
      #1;
      if (rd_valid_o === 1'b1) got.push_back(rd_data_o);
    end
    chk(16'({err_o, done_o}), 16'({e, ~e}));
  endtask : cmd
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [15:0] n,
                    input logic [7:0] b);
    int i;
    cmd(op, a, n, 1'b0);
    chk(16'(got.size()), n);
    for (i = 0; i < got.size(); i++) chk(16'(got[i]), 16'(8'(b + i)));
  endtask : rd
  task automatic t_latch;
    rd(8'h05, 24'h0, 16'h1, 8'h00);
    cmd(8'h06, 24'h0, 16'h0, 1'b0);
    rd(8'h05, 24'h0, 16'h1, 8'h02);
    rd(8'h35, 24'h0, 16'h1, 8'h00);
    cmd(8'h04, 24'h0, 16'h0, 1'b0);
    rd(8'h05, 24'h0, 16'h1, 8'h00);
  endtask : t_latch
  task automatic t_reset;
    cmd(8'h06, 24'h0, 16'h0, 1'b0);
    cmd(8'h99, 24'h0, 16'h0, 1'b1);
    cmd(8'h66, 24'h0, 16'h0, 1'b0);
    cmd(8'h99, 24'h0, 16'h0, 1'b0);
    rd(8'h05, 24'h0, 16'h1, 8'h00);
  endtask : t_reset
  task automatic t_refuse;
    cmd(8'heb, 24'h0, 16'h1, 1'b1);
    cmd(8'h03, 24'h200000, 16'h1, 1'b1);
    cmd(8'h60, 24'hffffff, 16'h0, 1'b0);
    cmd(8'h3b, 24'h0, 16'h1, 1'b0);
    quad_ok_i <= 1'b1;
    cmd(8'heb, 24'h0, 16'h1, 1'b0);
    quad_ok_i <= 1'b0;
  endtask : t_refuse
  task automatic t_read;
    rd(8'h03, 24'h1ffffe, 16'h3, 8'hfe);
    rd(8'h0b, 24'h000010, 16'h2, 8'h10);
    fork
      rd(8'h0b, 24'h000040, 16'h2, 8'h40);
      begin
        repeat (200) @(posedge sys_clk_i);
        pause_req_i <= 1'b1;
        repeat (100) @(posedge sys_clk_i);
        pause_req_i <= 1'b0;
      end
    join
  endtask : t_read
  task automatic t_fifo;
    int k;
    cmd(8'h06, 24'h0, 16'h0, 1'b0);
    @(posedge sys_clk_i);
    wr_valid_i <= 1'b1;
    for (k = 0; k < 8; k++) begin
      wr_data_i <= 8'(k);
      @(posedge sys_clk_i);
    end
    wr_valid_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk(16'(wr_ready_o), 16'h0000);
    cmd(8'h02, 24'h000100, 16'h8, 1'b0);
    chk(16'(wr_ready_o), 16'h0001);
    rd(8'h05, 24'h0, 16'h1, 8'h00);
  endtask : t_fifo
  task automatic conclude;
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_latch();
    t_reset();
    t_refuse();
    t_read();
    t_fifo();
    conclude();
  end
  initial begin
    #600000;
    n_errors++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
